// file: bcm_divider.sv
// Serial divider giving a saturated Q1.23 speed from scale and period.
// Assumes start is a one-cycle pulse on the same clock; 48 cycles from start to result.
`timescale 1ns/10ps
`include "bcm_map.svh"

module bcm_divider (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        start_i,
   input  wire logic [23:0] scale_i,
   input  wire logic [23:0] period_i,
   output logic             done_o,
   output logic [23:0]      quot_o
);

   // ****************************************************************
   // Restoring division of scale * 2^23 by period
   // ****************************************************************
   bcm_pkg::bcm_div_e state_reg;
   logic [46:0]       num_reg;
   logic [46:0]       quot_reg;
   logic [24:0]       rem_reg;
   logic [23:0]       den_reg;
   logic [5:0]        cnt_reg;
   logic [24:0]       rem_shift;
   logic              fits;

   assign rem_shift = {rem_reg[23:0], num_reg[46]};
   assign fits      = rem_shift >= {1'b0, den_reg};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= bcm_pkg::BCM_DIV_IDLE;
         num_reg   <= 47'h0;
         quot_reg  <= 47'h0;
         rem_reg   <= 25'h0;
         den_reg   <= 24'h0;
         cnt_reg   <= 6'h0;
         done_o    <= 1'b0;
         quot_o    <= 24'h0;
      end else begin
         done_o <= 1'b0;
         case (state_reg)
            bcm_pkg::BCM_DIV_IDLE: begin
               if (start_i) begin
                  num_reg   <= {scale_i, 23'h0};
                  den_reg   <= period_i;
                  rem_reg   <= 25'h0;
                  quot_reg  <= 47'h0;
                  cnt_reg   <= 6'd47;
                  state_reg <= bcm_pkg::BCM_DIV_RUN;
               end
            end
            bcm_pkg::BCM_DIV_RUN: begin
               if (cnt_reg == 6'h0) begin
                  // Zero period or overflow saturates to full speed
                  if (den_reg == 24'h0 || quot_reg[46:23] != 24'h0) begin
                     quot_o <= `BCM_Q23_MAX;
                  end else begin
                     quot_o <= quot_reg[23:0];
                  end
                  done_o    <= 1'b1;
                  state_reg <= bcm_pkg::BCM_DIV_IDLE;
               end else begin
                  num_reg  <= {num_reg[45:0], 1'b0};
                  rem_reg  <= fits ? (rem_shift - {1'b0, den_reg}) : rem_shift;
                  quot_reg <= {quot_reg[45:0], fits};
                  cnt_reg  <= cnt_reg - 6'h1;
               end
            end
            default: state_reg <= bcm_pkg::BCM_DIV_IDLE;
         endcase
      end
   end

endmodule // bcm_divider

// file: bcm_map.svh
// Offsets, field positions, reset values and timing counts of the speed block.
// Assumes byte addressing on an 8-bit Wishbone address, one 32-bit word per register.
`ifndef BCM_MAP_SVH
`define BCM_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define BCM_ADR_CTRL        8'h00
`define BCM_ADR_SCALE       8'h04
`define BCM_ADR_DUTY        8'h08
`define BCM_ADR_GAIN_IN     8'h0c
`define BCM_ADR_GAIN_OUT    8'h10
`define BCM_ADR_STATUS      8'h14
`define BCM_ADR_REV_PERIOD  8'h18
`define BCM_ADR_SEC_PERIOD  8'h1c
`define BCM_ADR_OMEGA       8'h20
`define BCM_ADR_PHASES      8'h24
`define BCM_ADR_CMD_BASE    8'h40
`define BCM_CMD_WORDS       24

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BCM_CTRL_SECTOR_BIT 0
`define BCM_CTRL_COMM_BIT   1
`define BCM_CTRL_RESET      2'h2
`define BCM_STAT_DIR_BIT    4
`define BCM_GAIN_FMT_BIT    24
`define BCM_Q23_MAX         24'h7fffff
`define BCM_Q23_MIN         24'h800000
`define BCM_SECTORS         3'h6

// ****************************************************************
// Timing
// ****************************************************************
`define BCM_CLK_HZ          10000000
`define BCM_CALC_PERIOD_US  100
`define BCM_CALC_CYCLES     ((`BCM_CALC_PERIOD_US * `BCM_CLK_HZ) / 1000000)

`endif

// file: bcm_motor_model.sv
// Hall sensor and power stage stand-in for the speed block.
// Assumes the bench pulses step_i for one clk_i cycle per sector.
`timescale 1ns/10ps
module bcm_motor_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       step_i,
   input  wire logic       dir_i,
   input  wire logic [2:0] pwm_pat_i,
   output logic [2:0]      hall_o,
   output logic [2:0]      pwm_o
);
   // Six sector codes, sector 0 in the low bits
   localparam logic [17:0] SEQ = 18'h2cc99;
   logic [2:0] sec_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i)
         sec_reg <= 3'h0;
      else if (step_i && dir_i)
         sec_reg <= (sec_reg == 3'h0) ? 3'h5 : sec_reg - 3'h1;
      else if (step_i)
         sec_reg <= (sec_reg == 3'h5) ? 3'h0 : sec_reg + 3'h1;
   end
   // One code bit flips per step, as real sensors do
   assign hall_o = SEQ[5'(sec_reg) * 5'd3 +: 3];
   always_ff @(posedge clk_i) begin
      pwm_o <= pwm_pat_i;
   end
endmodule // bcm_motor_model

// file: bcm_pkg.sv
// Types shared by the speed and commutation block.
// Assumes the constants of bcm_map.svh for all numbers.
package bcm_pkg;

   // ****************************************************************
   // Fractions and commands
   // ****************************************************************
   typedef logic signed [23:0] bcm_q23_t;

   typedef enum logic [1:0] {
      BCM_ON_HIGH  = 2'b00,
      BCM_ON_LOW   = 2'b01,
      BCM_OFF_LOW  = 2'b10,
      BCM_OFF_HIGH = 2'b11
   } bcm_chan_state_e;

   typedef struct packed {
      logic [7:0] option;
      logic [7:0] comp_state;
      logic [7:0] base_state;
      logic [7:0] chan;
   } bcm_cmd_s;

   typedef struct packed {
      bcm_chan_state_e base_state;
      bcm_chan_state_e comp_state;
      logic            invert_duty_sign;
      logic            pending_sign;
   } bcm_phase_s;

   typedef enum logic [1:0] {
      BCM_COMM_IDLE = 2'b00,
      BCM_COMM_OFF  = 2'b01,
      BCM_COMM_ON   = 2'b10
   } bcm_comm_e;

   typedef enum logic {
      BCM_DIV_IDLE = 1'b0,
      BCM_DIV_RUN  = 1'b1
   } bcm_div_e;

endpackage

// file: bcm_speed_comm.sv
// Hall decoding, speed estimate and commutation of three PWM phase pairs.
// Assumes Hall pins are asynchronous, pwm_i comes from a generator on clk_i,
// and software sets up tables over classic Wishbone.
`timescale 1ns/10ps
`include "bcm_map.svh"

module bcm_speed_comm (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic [2:0]  hall_i,
   input  wire logic [2:0]  pwm_i,
   output logic [2:0]       base_pin_o,
   output logic [2:0]       comp_pin_o,
   output logic [71:0]      phase_duty_o,
   output logic [23:0]      omega_o
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [1:0]          ctrl_reg;
   logic [23:0]         scale_reg;
   bcm_pkg::bcm_q23_t   duty_reg;
   logic [31:0]         gain_in_reg;
   logic [24:0]         gain_out_reg;
   logic [31:0]         cmd_mem [0:`BCM_CMD_WORDS-1];
   logic [2:0]          hall_meta_reg;
   logic [2:0]          hall_sync_reg;
   logic [2:0]          hall_prev_reg;
   logic [23:0]         time_base_one_reg;
   logic [23:0]         edge_time_reg [0:5];
   logic [23:0]         last_edge_reg;
   logic [23:0]         rev_period_reg;
   logic [23:0]         sec_period_reg;
   logic [2:0]          sector_reg;
   logic                dir_reg;
   logic [9:0]          calc_cnt_reg;
   logic                calc_start;
   logic                div_done;
   logic [23:0]         div_quot;
   logic                ack_reg;
   logic                wr_fire;
   logic [31:0]         rd_data;
   logic [2:0]          hall_edges;
   logic [1:0]          edge_phase;
   logic                edge_rise;
   logic [2:0]          new_sector;
   logic                new_dir;
   logic                hall_event;
   logic [4:0]          cmd_idx_reg;
   bcm_pkg::bcm_comm_e  comm_reg;
   bcm_pkg::bcm_cmd_s   cmd_cur;
   bcm_pkg::bcm_phase_s phase_reg [0:2];
   logic [2:0]          edge_slot;
   logic [4:0]          cmd_word;

   // Table index: phase, edge, direction, command number
   function automatic logic [4:0] cmd_index(input logic [1:0] ph, input logic rise,
                                             input logic dir, input logic second);
      cmd_index = 5'({ph, rise, dir, second});
   endfunction

   function automatic logic [2:0] hall_sector(input logic [2:0] code);
      case (code)
         3'b001:  hall_sector = 3'h0;
         3'b011:  hall_sector = 3'h1;
         3'b010:  hall_sector = 3'h2;
         3'b110:  hall_sector = 3'h3;
         3'b100:  hall_sector = 3'h4;
         3'b101:  hall_sector = 3'h5;
         default: hall_sector = 3'h7;
      endcase
   endfunction
   function automatic logic cmd_hit(input logic [7:0] a);
      return a >= `BCM_ADR_CMD_BASE && a < `BCM_ADR_CMD_BASE + 8'(4 * `BCM_CMD_WORDS)
             && a[1:0] == 2'b00;
   endfunction

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   // Answer one cycle after the request; ack drops the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_o   <= 32'h0;
      end else begin
         ack_reg <= cyc_i & stb_i & ~ack_reg;
         dat_o   <= rd_data;
      end
   end
   assign ack_o   = ack_reg;
   assign wr_fire = cyc_i & stb_i & we_i & ack_reg & (sel_i == 4'hf);
   assign cmd_word = 5'((adr_i - `BCM_ADR_CMD_BASE) >> 2);

   always_comb begin
      rd_data = 32'h0;
      case (adr_i)
         `BCM_ADR_CTRL:       rd_data = {30'h0, ctrl_reg};
         `BCM_ADR_SCALE:      rd_data = {8'h0, scale_reg};
         `BCM_ADR_DUTY:       rd_data = {8'h0, duty_reg};
         `BCM_ADR_GAIN_IN:    rd_data = gain_in_reg;
         `BCM_ADR_GAIN_OUT:   rd_data = {7'h0, gain_out_reg};
         `BCM_ADR_STATUS:     rd_data = {27'h0, dir_reg, 1'b0, sector_reg};
         `BCM_ADR_REV_PERIOD: rd_data = {8'h0, rev_period_reg};
         `BCM_ADR_SEC_PERIOD: rd_data = {8'h0, sec_period_reg};
         `BCM_ADR_OMEGA:      rd_data = {8'h0, omega_o};
         `BCM_ADR_PHASES:     rd_data = {14'h0, phase_reg[2], phase_reg[1], phase_reg[0]};
         default: begin
            if (cmd_hit(adr_i)) begin
               rd_data = cmd_mem[cmd_word];
            end
         end
      endcase
   end

   // ****************************************************************
   // Software registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg    <= `BCM_CTRL_RESET;
         scale_reg   <= 24'h0;
         duty_reg    <= 24'h0;
         gain_in_reg <= 32'h0;
      end else if (wr_fire) begin
         case (adr_i)
            `BCM_ADR_CTRL:    ctrl_reg    <= dat_i[1:0];
            `BCM_ADR_SCALE:   scale_reg   <= dat_i[23:0];
            `BCM_ADR_DUTY:    duty_reg    <= dat_i[23:0];
            `BCM_ADR_GAIN_IN: gain_in_reg <= dat_i;
            default: ;
         endcase
      end
   end

   // Table contents are stored as written; no reset needed
   always_ff @(posedge clk_i) begin
      if (wr_fire && cmd_hit(adr_i)) begin
         cmd_mem[cmd_word] <= dat_i;
      end
   end

   // Small gains keep 23 fraction bits, large ones drop to 15
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_out_reg <= 25'h0;
      end else if (gain_in_reg[31:23] == {9{gain_in_reg[23]}}) begin
         gain_out_reg <= {1'b0, gain_in_reg[23:0]};
      end else begin
         gain_out_reg <= {1'b1, gain_in_reg[31:8]};
      end
   end

   // ****************************************************************
   // Hall inputs and timer base
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hall_meta_reg     <= 3'h0;
         hall_sync_reg     <= 3'h0;
         hall_prev_reg     <= 3'h0;
         time_base_one_reg <= 24'h0;
      end else begin
         hall_meta_reg     <= hall_i;
         hall_sync_reg     <= hall_meta_reg;
         hall_prev_reg     <= hall_sync_reg;
         time_base_one_reg <= time_base_one_reg + 24'h1;
      end
   end

   assign hall_edges = hall_sync_reg ^ hall_prev_reg;
   // Reset leaves 000 behind; the first real sample is no edge
   assign hall_event = |hall_edges && hall_prev_reg != 3'h0;

   // Lowest channel wins if two sensors move together; never in a sane motor
   always_comb begin
      edge_phase = 2'h0;
      if (hall_edges[0]) begin
         edge_phase = 2'h0;
      end else if (hall_edges[1]) begin
         edge_phase = 2'h1;
      end else if (hall_edges[2]) begin
         edge_phase = 2'h2;
      end
   end
   assign edge_rise  = hall_sync_reg[edge_phase];
   assign edge_slot  = 3'({edge_phase, edge_rise});
   assign new_sector = hall_sector(hall_sync_reg);
   // Forward step of the sector sequence means incremental
   assign new_dir    = ~((sector_reg == `BCM_SECTORS - 3'h1) ? (new_sector == 3'h0)
                                                           : (new_sector == sector_reg + 3'h1));

   // ****************************************************************
   // Period measurement
   // ****************************************************************
   // One electrical turn spans six sectors, back to the same edge
   // The period is electrical; poles are folded into the scale
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 6; i++) begin
            edge_time_reg[i] <= 24'h0;
         end
         last_edge_reg  <= 24'h0;
         rev_period_reg <= 24'h0;
         sec_period_reg <= 24'h0;
         sector_reg     <= 3'h0;
         dir_reg        <= 1'b0;
      end else if (hall_event) begin
         edge_time_reg[edge_slot] <= time_base_one_reg;
         rev_period_reg <= time_base_one_reg - edge_time_reg[edge_slot];
         sec_period_reg <= time_base_one_reg - last_edge_reg;
         last_edge_reg  <= time_base_one_reg;
         if (new_sector != 3'h7) begin
            sector_reg <= new_sector;
            dir_reg    <= new_dir;
         end
      end
   end

   // ****************************************************************
   // Speed estimate
   // ****************************************************************
   // Tick every 100 us, two PWM periods at 20 kHz
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         calc_cnt_reg <= 10'h0;
      end else if (calc_cnt_reg == 10'(`BCM_CALC_CYCLES - 1)) begin
         calc_cnt_reg <= 10'h0;
      end else begin
         calc_cnt_reg <= calc_cnt_reg + 10'h1;
      end
   end
   assign calc_start = calc_cnt_reg == 10'(`BCM_CALC_CYCLES - 1);

   // Sector period times six stands in for a turn
   // Result is a Q1.23 fraction of the speed range
   bcm_divider u_divider (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (calc_start),
      .scale_i  (ctrl_reg[`BCM_CTRL_SECTOR_BIT] ? 24'(scale_reg / 24'd6) : scale_reg),
      .period_i (ctrl_reg[`BCM_CTRL_SECTOR_BIT] ? sec_period_reg : rev_period_reg),
      .done_o   (div_done),
      .quot_o   (div_quot)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         omega_o <= 24'h0;
      end else if (div_done) begin
         omega_o <= div_quot;
      end
   end

   // ****************************************************************
   // Commutation
   // ****************************************************************
   // Off command first, then on command
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comm_reg    <= bcm_pkg::BCM_COMM_IDLE;
         cmd_idx_reg <= 5'h0;
      end else begin
         case (comm_reg)
            bcm_pkg::BCM_COMM_IDLE: begin
               if (hall_event && ctrl_reg[`BCM_CTRL_COMM_BIT] && new_sector != 3'h7) begin
                  cmd_idx_reg <= cmd_index(edge_phase, edge_rise, new_dir, 1'b0);
                  comm_reg    <= bcm_pkg::BCM_COMM_OFF;
               end
            end
            bcm_pkg::BCM_COMM_OFF: begin
               cmd_idx_reg <= cmd_idx_reg | 5'h1;
               comm_reg    <= bcm_pkg::BCM_COMM_ON;
            end
            bcm_pkg::BCM_COMM_ON: comm_reg <= bcm_pkg::BCM_COMM_IDLE;
            default:              comm_reg <= bcm_pkg::BCM_COMM_IDLE;
         endcase
      end
   end
   assign cmd_cur = bcm_pkg::bcm_cmd_s'(cmd_mem[cmd_idx_reg]);

   generate
      for (genvar p = 0; p < 3; p++) begin : g_phase
         logic turns_on;
         logic [23:0] neg_duty;

         assign turns_on = ~cmd_cur.base_state[1];

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               phase_reg[p] <= '{bcm_pkg::BCM_OFF_LOW, bcm_pkg::BCM_OFF_LOW, 1'b0, 1'b0};
            end else if (comm_reg != bcm_pkg::BCM_COMM_IDLE && cmd_cur.chan == 8'(p)) begin
               phase_reg[p].base_state <= bcm_pkg::bcm_chan_state_e'(cmd_cur.base_state[1:0]);
               phase_reg[p].comp_state <= bcm_pkg::bcm_chan_state_e'(cmd_cur.comp_state[1:0]);
               if (turns_on) begin
                  phase_reg[p].invert_duty_sign <= cmd_cur.option[0];
               end else begin
                  phase_reg[p].pending_sign <= cmd_cur.option[0];
               end
            end else if (phase_reg[p].base_state[1] == 1'b1) begin
               // Stored option is copied to the duty sign on every cycle the phase is off and no command targets it
               phase_reg[p].invert_duty_sign <= phase_reg[p].pending_sign;
            end
         end

         // Negating minus one saturates to the largest fraction
         assign neg_duty = (duty_reg == `BCM_Q23_MIN) ? `BCM_Q23_MAX : 24'(-duty_reg);

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               phase_duty_o[24*p +: 24] <= 24'h0;
               base_pin_o[p]            <= 1'b0;
               comp_pin_o[p]            <= 1'b0;
            end else begin
               phase_duty_o[24*p +: 24] <= phase_reg[p].invert_duty_sign ? neg_duty
                                                                          : duty_reg;
               case (phase_reg[p].base_state)
                  bcm_pkg::BCM_ON_HIGH: base_pin_o[p] <= pwm_i[p];
                  bcm_pkg::BCM_ON_LOW:  base_pin_o[p] <= ~pwm_i[p];
                  bcm_pkg::BCM_OFF_LOW: base_pin_o[p] <= 1'b0;
                  default:              base_pin_o[p] <= 1'b1;
               endcase
               case (phase_reg[p].comp_state)
                  bcm_pkg::BCM_ON_HIGH: comp_pin_o[p] <= pwm_i[p];
                  bcm_pkg::BCM_ON_LOW:  comp_pin_o[p] <= ~pwm_i[p];
                  bcm_pkg::BCM_OFF_LOW: comp_pin_o[p] <= 1'b0;
                  default:              comp_pin_o[p] <= 1'b1;
               endcase
            end
         end
      end
   endgenerate

endmodule // bcm_speed_comm

// file: bcm_speed_comm_assertions.sv
// Port checker for the speed and commutation block.
// Assumes it is bound into bcm_speed_comm; one clock domain.
`timescale 1ns/10ps
module bcm_speed_comm_assertions (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   input wire logic [2:0]  hall_i,
   input wire logic [2:0]  pwm_i,
   input wire logic [2:0]  base_pin_o,
   input wire logic [2:0]  comp_pin_o,
   input wire logic [71:0] phase_duty_o,
   input wire logic [23:0] omega_o
);
   logic [23:0] omega_q;
   logic [9:0]  gap_reg;
   always_ff @(posedge clk_i) begin
      omega_q <= omega_o;
   end
   // Saturating, so long quiet spells cannot wrap
   always_ff @(posedge clk_i) begin
      if (rst_i || omega_o != omega_q)
         gap_reg <= 10'h0;
      else if (gap_reg != 10'h3ff)
         gap_reg <= gap_reg + 10'h1;
   end
   function automatic logic mag(input logic [23:0] a, input logic [23:0] b);
      return a == b || a == -b || (a == 24'h7fffff && b == 24'h800000)
         || (a == 24'h800000 && b == 24'h7fffff);
   endfunction
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack late");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   a_reset_state: assert property (disable iff (1'b0) rst_i |=> !ack_o && omega_o == 24'h0
      && phase_duty_o == 72'h0 && base_pin_o == 3'h0 && comp_pin_o == 3'h0)
      else $error("reset state wrong");
   a_omega_sign: assert property (!omega_o[23])
      else $error("speed negative");
   a_omega_gap: assert property (omega_o != omega_q |-> gap_reg >= 10'd990)
      else $error("speed updated too soon");
   a_omega_hold: assert property ($changed(omega_o) |=> $stable(omega_o)[*8])
      else $error("speed not held");
   a_pins_hold: assert property (($stable(hall_i) && $stable(pwm_i))[*8] |=>
      $stable({base_pin_o, comp_pin_o})) else $error("pins moved alone");
   a_duty_mag_b: assert property (mag(phase_duty_o[47:24], phase_duty_o[23:0]))
      else $error("phase b duty magnitude");
   a_duty_mag_c: assert property (mag(phase_duty_o[71:48], phase_duty_o[23:0]))
      else $error("phase c duty magnitude");
endmodule // bcm_speed_comm_assertions

// file: bcm_speed_comm_bench.sv
// Self-checking bench for the speed and commutation block.
// Assumes the package, map header, motor stand-in and checker come first.
`timescale 1ns/10ps
`include "bcm_map.svh"
module bcm_speed_comm_bench;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h0;
   logic [3:0]  sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic        ack_o, step = 1'b0, dir = 1'b0;
   logic [2:0]  hall, pwm, pat = 3'h5, bp, cp;
   logic [71:0] duty_o;
   logic [23:0] omega_o, lfsr = 24'h2a, d = 24'h0;
   logic [31:0] expq [$];
   int          miscompares = 0, tests_run = 0, cyc = 0;
   always #50 clk_i = ~clk_i;
   bcm_speed_comm dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .hall_i(hall), .pwm_i(pwm), .base_pin_o(bp), .comp_pin_o(cp),
      .phase_duty_o(duty_o), .omega_o);
   bcm_motor_model mot_u (.clk_i, .rst_i, .step_i(step), .dir_i(dir), .pwm_pat_i(pat),
      .hall_o(hall), .pwm_o(pwm));
   function automatic logic [23:0] next_rand(input logic [23:0] v);
      return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
   endfunction
   // Negation saturates at the top fraction
   function automatic logic [23:0] ng(input logic [23:0] v);
      return (v == 24'h800000) ? 24'h7fffff : -v;
   endfunction
   // Off command for idx then on command, by phase, edge, direction
   function automatic logic [31:0] cmd(input logic [4:0] i);
      logic [7:0] p;
      p = {6'h0, i[4:3]};
      if (i[0])
         return {7'h0, !i[2], 8'h1, 7'h0, i[1], p};
      return {7'h0, i[2], 8'h3, 8'h2, (p == 8'h2) ? 8'h0 : p + 8'h1};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] s);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= v;
      sel_i <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask
   // Steps gap cycles apart, then checks the two phases just commuted
   task automatic turn(input logic dn, input int n, input int gap);
      int p, q;
      logic [2:0] h;
      logic r;
      repeat (n) begin
         h = hall;
         lfsr = next_rand(lfsr);
         pat <= lfsr[2:0];
         dir <= dn;
         step <= 1'b1;
         @(posedge clk_i);
         step <= 1'b0;
         repeat (gap - 1) @(posedge clk_i);
         p = (h[0] != hall[0]) ? 0 : ((h[1] != hall[1]) ? 1 : 2);
         q = (p == 2) ? 0 : p + 1;
         r = hall[p];
         check({bp[p], cp[p], bp[q], cp[q]}, {pat[p] ^ dn, ~pat[p], 2'b01});
         check({8'h0, duty_o[24*p +: 24]}, {8'h0, r ? d : ng(d)});
         check({8'h0, duty_o[24*q +: 24]}, {8'h0, r ? ng(d) : d});
      end
   endtask
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0)
         check(dat_o, expq.pop_front());
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(`BCM_ADR_CTRL, 32'h2);
      rd(8'h30, 32'h0);
      rd(`BCM_ADR_PHASES, 32'h28a28);
      wb(1'b1, `BCM_ADR_CTRL, 32'h0, 4'h1);
      wb(1'b1, `BCM_ADR_OMEGA, 32'h1234, 4'hf);
      rd(`BCM_ADR_CTRL, 32'h2);
      repeat (1100) @(posedge clk_i);
      rd(`BCM_ADR_OMEGA, 32'h7fffff);
      wb(1'b1, `BCM_ADR_GAIN_IN, 32'h00400000, 4'hf);
      rd(`BCM_ADR_GAIN_OUT, 32'h00400000);
      wb(1'b1, `BCM_ADR_GAIN_IN, 32'hff800000, 4'hf);
      rd(`BCM_ADR_GAIN_OUT, 32'h00800000);
      wb(1'b1, `BCM_ADR_GAIN_IN, 32'hfb000000, 4'hf);
      rd(`BCM_ADR_GAIN_OUT, 32'h01fb0000);
      for (int i = 0; i < 24; i++)
         wb(1'b1, `BCM_ADR_CMD_BASE + 8'(4 * i), cmd(5'(i)), 4'hf);
      rd(8'hc0, 32'h0);
      lfsr = next_rand(lfsr);
      d = lfsr;
      wb(1'b1, `BCM_ADR_DUTY, {8'h0, d}, 4'hf);
      wb(1'b1, `BCM_ADR_SCALE, 32'h30, 4'hf);
      turn(1'b0, 30, 40);
      turn(1'b0, 1, 80);
      turn(1'b0, 1, 40);
      rd(`BCM_ADR_REV_PERIOD, 32'd280);
      rd(`BCM_ADR_SEC_PERIOD, 32'd80);
      rd(`BCM_ADR_STATUS, 32'h2);
      repeat (1100) @(posedge clk_i);
      rd(`BCM_ADR_OMEGA, (32'h30 << 23) / 280);
      check({8'h0, omega_o}, (32'h30 << 23) / 280);
      wb(1'b1, `BCM_ADR_CTRL, 32'h3, 4'hf);
      repeat (1100) @(posedge clk_i);
      rd(`BCM_ADR_OMEGA, ((32'h30 / 6) << 23) / 80);
      turn(1'b1, 7, 40);
      rd(`BCM_ADR_STATUS, 32'h11);
      wb(1'b1, `BCM_ADR_CTRL, 32'h1, 4'hf);
      d = {18'h0, bp, cp};
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (40) @(posedge clk_i);
      check({26'h0, bp, cp}, {8'h0, d});
      summarize();
   end
endmodule // bcm_speed_comm_bench
bind bcm_speed_comm bcm_speed_comm_assertions chk_u (.clk_i, .rst_i, .cyc_i, .stb_i,
   .ack_o, .hall_i, .pwm_i, .base_pin_o, .comp_pin_o, .phase_duty_o, .omega_o);
